// [afe_timing_offset_gain_regs.sv]
// timing, clamp, id, offset and gain registers of the three-channel front end
`timescale 1ns/100ps
`default_nettype none
module afe_timing_offset_gain_regs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [afe_regs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [afe_regs_pkg::DATA_W-1:0] reg_wr_data,
   output logic [afe_regs_pkg::DATA_W-1:0] reg_rd_data,
   input wire logic sync_timing_mode,
   input wire logic [afe_regs_pkg::REFT_W-1:0] reference_sample_timing,
   input wire logic reference_sample_pin,
   input wire logic video_sample_pin,
   output logic timing_pulse,
   output logic reset_level_clamp,
   output logic [afe_regs_pkg::DATA_W-1:0] red_offset_code,
   output logic [afe_regs_pkg::DATA_W-1:0] green_offset_code,
   output logic [afe_regs_pkg::DATA_W-1:0] blue_offset_code,
   output logic [afe_regs_pkg::GAIN_W-1:0] red_gain_code,
   output logic [afe_regs_pkg::GAIN_W-1:0] green_gain_code,
   output logic [afe_regs_pkg::GAIN_W-1:0] blue_gain_code
);
   // ****************************************
   // storage
   // ****************************************
   logic [afe_regs_pkg::DATA_W-1:0] sample_timing_clamp_setup_r;
   logic [afe_regs_pkg::DATA_W-1:0] user_id_scratch_r;
   logic [afe_regs_pkg::DATA_W-1:0] red_offset_value_r;
   logic [afe_regs_pkg::DATA_W-1:0] green_offset_value_r;
   logic [afe_regs_pkg::DATA_W-1:0] blue_offset_value_r;
   logic red_gain_low_bit_r;
   logic green_gain_low_bit_r;
   logic blue_gain_low_bit_r;
   logic [afe_regs_pkg::DATA_W-1:0] red_gain_upper_byte_r;
   logic [afe_regs_pkg::DATA_W-1:0] green_gain_upper_byte_r;
   logic [afe_regs_pkg::DATA_W-1:0] blue_gain_upper_byte_r;
   logic [afe_regs_pkg::DATA_W-1:0] rd_data_r;
   logic ref_s1_r, ref_s2_r, video_s1_r, video_s2_r;
   logic timing_r, clamp_r;
   logic [afe_regs_pkg::REFT_W-1:0] pixel_phase_r;
   logic video_edge_detect_enable, detect_edge_polarity;
   logic reset_level_clamp_enable, clamp_switch_source, detect_active;
   logic [afe_regs_pkg::DLY_W-1:0] detect_pulse_delay;
   logic [afe_regs_pkg::DATA_W-1:0] rd_nxt;

   detect_if det_bus ();

   // write strobe for one offset
   function automatic logic wr_hit(input logic en, input logic [afe_regs_pkg::ADDR_W-1:0] a,
                                   input logic [afe_regs_pkg::ADDR_W-1:0] ofs);
      wr_hit = en && (a == ofs);
   endfunction : wr_hit

   // ****************************************
   // setup fields
   // ****************************************
   assign video_edge_detect_enable = sample_timing_clamp_setup_r[afe_regs_pkg::DET_BIT];
   assign detect_pulse_delay = sample_timing_clamp_setup_r[afe_regs_pkg::DLY_LSB +: afe_regs_pkg::DLY_W];
   assign detect_edge_polarity = sample_timing_clamp_setup_r[afe_regs_pkg::POL_BIT];
   assign reset_level_clamp_enable = sample_timing_clamp_setup_r[afe_regs_pkg::RESET_LEVEL_CLAMP_ENABLE_BIT];
   assign clamp_switch_source = sample_timing_clamp_setup_r[afe_regs_pkg::CLPSRC_BIT];
   assign detect_active = sync_timing_mode && video_edge_detect_enable;

   // setup register; reserved bit 7 is not stored and reads zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sample_timing_clamp_setup_r <= afe_regs_pkg::SETUP_RESET;
      end else if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::SETUP_OFS)) begin
         sample_timing_clamp_setup_r <= reg_wr_data & afe_regs_pkg::SETUP_MASK;
      end
   end

   // id scratch keeps the low nibble only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         user_id_scratch_r <= afe_regs_pkg::BYTE_ZERO;
      end else if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ID_OFS)) begin
         user_id_scratch_r <= reg_wr_data & afe_regs_pkg::ID_MASK;
      end
   end

   // offset values; the broadcast address writes all three at once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         red_offset_value_r <= afe_regs_pkg::BYTE_ZERO;
         green_offset_value_r <= afe_regs_pkg::BYTE_ZERO;
         blue_offset_value_r <= afe_regs_pkg::BYTE_ZERO;
      end else if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_OFS_OFS)) begin
         red_offset_value_r <= reg_wr_data;
         green_offset_value_r <= reg_wr_data;
         blue_offset_value_r <= reg_wr_data;
      end else begin
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::RED_OFS_OFS)) red_offset_value_r <= reg_wr_data;
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::GRN_OFS_OFS)) green_offset_value_r <= reg_wr_data;
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::BLU_OFS_OFS)) blue_offset_value_r <= reg_wr_data;
      end
   end

   // gain low bits, taken from data bit 0
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         red_gain_low_bit_r <= 1'b0;
         green_gain_low_bit_r <= 1'b0;
         blue_gain_low_bit_r <= 1'b0;
      end else if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_LSB_OFS)) begin
         red_gain_low_bit_r <= reg_wr_data[0];
         green_gain_low_bit_r <= reg_wr_data[0];
         blue_gain_low_bit_r <= reg_wr_data[0];
      end else begin
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::RED_LSB_OFS)) red_gain_low_bit_r <= reg_wr_data[0];
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::GRN_LSB_OFS)) green_gain_low_bit_r <= reg_wr_data[0];
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::BLU_LSB_OFS)) blue_gain_low_bit_r <= reg_wr_data[0];
      end
   end

   // gain upper bytes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         red_gain_upper_byte_r <= afe_regs_pkg::GAIN_MSB_RESET;
         green_gain_upper_byte_r <= afe_regs_pkg::GAIN_MSB_RESET;
         blue_gain_upper_byte_r <= afe_regs_pkg::GAIN_MSB_RESET;
      end else if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_MSB_OFS)) begin
         red_gain_upper_byte_r <= reg_wr_data;
         green_gain_upper_byte_r <= reg_wr_data;
         blue_gain_upper_byte_r <= reg_wr_data;
      end else begin
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::RED_MSB_OFS)) red_gain_upper_byte_r <= reg_wr_data;
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::GRN_MSB_OFS)) green_gain_upper_byte_r <= reg_wr_data;
         if (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::BLU_MSB_OFS)) blue_gain_upper_byte_r <= reg_wr_data;
      end
   end

   // ****************************************
   // read back
   // ****************************************
   // broadcast and unmapped addresses read zero
   always_comb begin
      rd_nxt = afe_regs_pkg::BYTE_ZERO;
      if (reg_addr == afe_regs_pkg::SETUP_OFS) begin
         rd_nxt = sample_timing_clamp_setup_r;
      end else if (reg_addr == afe_regs_pkg::ID_OFS) begin
         rd_nxt = user_id_scratch_r;
      end else if (reg_addr == afe_regs_pkg::RED_OFS_OFS) begin
         rd_nxt = red_offset_value_r;
      end else if (reg_addr == afe_regs_pkg::GRN_OFS_OFS) begin
         rd_nxt = green_offset_value_r;
      end else if (reg_addr == afe_regs_pkg::BLU_OFS_OFS) begin
         rd_nxt = blue_offset_value_r;
      end else if (reg_addr == afe_regs_pkg::RED_LSB_OFS) begin
         rd_nxt = {7'h00, red_gain_low_bit_r};
      end else if (reg_addr == afe_regs_pkg::GRN_LSB_OFS) begin
         rd_nxt = {7'h00, green_gain_low_bit_r};
      end else if (reg_addr == afe_regs_pkg::BLU_LSB_OFS) begin
         rd_nxt = {7'h00, blue_gain_low_bit_r};
      end else if (reg_addr == afe_regs_pkg::RED_MSB_OFS) begin
         rd_nxt = red_gain_upper_byte_r;
      end else if (reg_addr == afe_regs_pkg::GRN_MSB_OFS) begin
         rd_nxt = green_gain_upper_byte_r;
      end else if (reg_addr == afe_regs_pkg::BLU_MSB_OFS) begin
         rd_nxt = blue_gain_upper_byte_r;
      end
   end

   // read data holds until the next read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data_r <= afe_regs_pkg::BYTE_ZERO;
      end else if (reg_rd_en) begin
         rd_data_r <= rd_nxt;
      end
   end

   // ****************************************
   // pins and timing
   // ****************************************
   // both sample pins are asynchronous to this clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ref_s1_r <= 1'b0;
         ref_s2_r <= 1'b0;
         video_s1_r <= 1'b0;
         video_s2_r <= 1'b0;
      end else begin
         ref_s1_r <= reference_sample_pin;
         ref_s2_r <= ref_s1_r;
         video_s1_r <= video_sample_pin;
         video_s2_r <= video_s1_r;
      end
   end

   assign det_bus.video_level = video_s2_r;
   assign det_bus.edge_rising = detect_edge_polarity;
   assign det_bus.pulse_delay = detect_pulse_delay;

   video_edge_delay u_edge (
      .clk_sys(clk_sys),
      .rst(rst),
      .det(det_bus)
   );

   // timing control sees either the pin or the generated pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timing_r <= 1'b0;
      end else if (detect_active) begin
         timing_r <= det_bus.pulse;
      end else begin
         timing_r <= video_s2_r;
      end
   end

   // pixel phase counter restarted by each timing event in sync mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pixel_phase_r <= afe_regs_pkg::REFT_ZERO;
      end else if (timing_r) begin
         pixel_phase_r <= afe_regs_pkg::REFT_ZERO;
      end else begin
         pixel_phase_r <= pixel_phase_r + 2'h1;
      end
   end

   // clamp switch; sync mode uses the pixel phase, else the pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clamp_r <= 1'b0;
      end else if (!reset_level_clamp_enable) begin
         clamp_r <= 1'b0;
      end else if (sync_timing_mode) begin
         clamp_r <= (pixel_phase_r == reference_sample_timing);
      end else if (clamp_switch_source) begin
         clamp_r <= ref_s2_r & video_s2_r;
      end else begin
         clamp_r <= ref_s2_r;
      end
   end

   assign reg_rd_data = rd_data_r;
   assign timing_pulse = timing_r;
   assign reset_level_clamp = clamp_r;
   assign red_offset_code = red_offset_value_r;
   assign green_offset_code = green_offset_value_r;
   assign blue_offset_code = blue_offset_value_r;
   assign red_gain_code = {red_gain_upper_byte_r, red_gain_low_bit_r};
   assign green_gain_code = {green_gain_upper_byte_r, green_gain_low_bit_r};
   assign blue_gain_code = {blue_gain_upper_byte_r, blue_gain_low_bit_r};

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_PASS_PIN: assert property (!detect_active |=> timing_r == $past(video_s2_r))
      else $error("timing output does not follow pin in bypass");
   AST_DELAY_ZERO: assert property (detect_active && det_bus.edge_seen && detect_pulse_delay == 3'h0
      ##1 detect_active |=> timing_r)
      else $error("zero delay pulse late");
   AST_DELAY_TWO: assert property (detect_active && det_bus.edge_seen && detect_pulse_delay == 3'h2
      ##1 (detect_active && !det_bus.edge_seen)[*3] |=> timing_r && $past(timing_r, 1) == 1'b0)
      else $error("delay of two not honoured");
   AST_POLARITY: assert property (det_bus.edge_seen |-> video_s2_r == detect_edge_polarity)
      else $error("edge of wrong polarity detected");
   AST_CLAMP_OFF: assert property (!reset_level_clamp_enable |=> !clamp_r)
      else $error("clamp closed while disabled");
   AST_CLAMP_DIRECT: assert property (reset_level_clamp_enable && !sync_timing_mode && !clamp_switch_source
      |=> clamp_r == $past(ref_s2_r))
      else $error("clamp not following reference pin");
   AST_CLAMP_AND: assert property (reset_level_clamp_enable && !sync_timing_mode && clamp_switch_source
      |=> clamp_r == $past(ref_s2_r && video_s2_r))
      else $error("clamp not the and of both pins");
   AST_CLAMP_SYNC: assert property (reset_level_clamp_enable && sync_timing_mode
      |=> clamp_r == ($past(pixel_phase_r) == $past(reference_sample_timing)))
      else $error("sync clamp at wrong phase");
   AST_ID_NIBBLE: assert property (user_id_scratch_r[7:4] == 4'h0)
      else $error("id upper nibble not zero");
   AST_BCAST_OFS: assert property (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_OFS_OFS)
      |=> red_offset_code == $past(reg_wr_data) && blue_offset_code == $past(reg_wr_data))
      else $error("broadcast offset not applied");
   AST_BCAST_LSB: assert property (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_LSB_OFS)
      |=> green_gain_code[0] == $past(reg_wr_data[0]))
      else $error("broadcast gain low bit not applied");
   AST_BCAST_MSB: assert property (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_MSB_OFS)
      |=> blue_gain_code[8:1] == $past(reg_wr_data))
      else $error("broadcast gain byte not applied");
   AST_GAIN_RESET: assert property (disable iff (1'b0) rst |=> red_gain_code == 9'h01A)
      else $error("gain reset value wrong");

   COV_DELAYED_PULSE: cover property (detect_active && detect_pulse_delay == 3'h7 && timing_r);
   COV_CLAMP_AND: cover property (clamp_switch_source && !sync_timing_mode && clamp_r);
   COV_BCAST_MSB: cover property (wr_hit(reg_wr_en, reg_addr, afe_regs_pkg::ALL_MSB_OFS));
endmodule : afe_timing_offset_gain_regs
`default_nettype wire

// [afe_regs_pkg.sv]
// constants for the front-end timing, offset and gain register bank
package afe_regs_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int DLY_W = 3;
   localparam int REFT_W = 2;
   localparam int GAIN_W = 9;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] SETUP_OFS = 6'h06;
   localparam logic [ADDR_W-1:0] ID_OFS = 6'h07;
   localparam logic [ADDR_W-1:0] RED_OFS_OFS = 6'h20;
   localparam logic [ADDR_W-1:0] GRN_OFS_OFS = 6'h21;
   localparam logic [ADDR_W-1:0] BLU_OFS_OFS = 6'h22;
   localparam logic [ADDR_W-1:0] ALL_OFS_OFS = 6'h23;
   localparam logic [ADDR_W-1:0] RED_LSB_OFS = 6'h24;
   localparam logic [ADDR_W-1:0] GRN_LSB_OFS = 6'h25;
   localparam logic [ADDR_W-1:0] BLU_LSB_OFS = 6'h26;
   localparam logic [ADDR_W-1:0] ALL_LSB_OFS = 6'h27;
   localparam logic [ADDR_W-1:0] RED_MSB_OFS = 6'h28;
   localparam logic [ADDR_W-1:0] GRN_MSB_OFS = 6'h29;
   localparam logic [ADDR_W-1:0] BLU_MSB_OFS = 6'h2A;
   localparam logic [ADDR_W-1:0] ALL_MSB_OFS = 6'h2B;
   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int DET_BIT = 0;
   localparam int DLY_LSB = 1;
   localparam int POL_BIT = 4;
   localparam int RESET_LEVEL_CLAMP_ENABLE_BIT = 5;
   localparam int CLPSRC_BIT = 6;
   localparam logic [DATA_W-1:0] SETUP_MASK = 8'h7F;
   localparam logic [DATA_W-1:0] ID_MASK = 8'h0F;
   localparam logic [DATA_W-1:0] SETUP_RESET = 8'h20;
   localparam logic [DATA_W-1:0] GAIN_MSB_RESET = 8'h0D;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DLY_W-1:0] DLY_ZERO = 3'h0;
   localparam logic [REFT_W-1:0] REFT_ZERO = 2'h0;
endpackage : afe_regs_pkg

// [detect_if.sv]
// carrier between the register bank and the video-edge detector
`timescale 1ns/100ps
`default_nettype none
interface detect_if;
   logic video_level;
   logic edge_rising;
   logic [afe_regs_pkg::DLY_W-1:0] pulse_delay;
   logic pulse;
   logic edge_seen;
   modport bank (output video_level, output edge_rising, output pulse_delay, input pulse, input edge_seen);
   modport detector (input video_level, input edge_rising, input pulse_delay, output pulse, output edge_seen);
endinterface : detect_if
`default_nettype wire

// [video_edge_delay.sv]
// video-pin edge detector with a programmable delay in sample clocks
`timescale 1ns/100ps
`default_nettype none
module video_edge_delay (
   input wire logic clk_sys,
   input wire logic rst,
   detect_if.detector det
);
   logic level_prev_r;
   logic armed_r;
   logic [afe_regs_pkg::DLY_W-1:0] count_r;
   logic pulse_r;
   logic edge_now;

   // edge of the chosen polarity, already synchronised by the bank
   assign edge_now = det.edge_rising ? (det.video_level & ~level_prev_r)
                                     : (~det.video_level & level_prev_r);
   assign det.edge_seen = edge_now;
   assign det.pulse = pulse_r;

   // history of the synchronised level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         level_prev_r <= 1'b0;
      end else begin
         level_prev_r <= det.video_level;
      end
   end

   // a new edge restarts the countdown; an old pending pulse is dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         armed_r <= 1'b0;
         count_r <= afe_regs_pkg::DLY_ZERO;
         pulse_r <= 1'b0;
      end else if (edge_now) begin
         armed_r <= (det.pulse_delay != afe_regs_pkg::DLY_ZERO);
         count_r <= det.pulse_delay;
         pulse_r <= (det.pulse_delay == afe_regs_pkg::DLY_ZERO);
      end else if (armed_r) begin
         count_r <= count_r - 3'h1;
         armed_r <= (count_r != 3'h1);
         pulse_r <= (count_r == 3'h1);
      end else begin
         pulse_r <= 1'b0;
      end
   end
endmodule : video_edge_delay
`default_nettype wire

// [host_model.sv]
// host model that drives the register port of the front end
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk_sys,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [afe_regs_pkg::ADDR_W-1:0] reg_addr,
   output logic [afe_regs_pkg::DATA_W-1:0] reg_wr_data,
   input wire logic [afe_regs_pkg::DATA_W-1:0] reg_rd_data
);
   // idle bus at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 6'h00;
      reg_wr_data = 8'h00;
   end
   // one-cycle write strobe; callers keep reserved bits at zero
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wr_data = d;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
      reg_wr_data = ~d; // scrambled so a stale byte can never pass for a write
      @(negedge clk_sys);
   endtask : wr
   // read data is taken a full cycle after the strobe edge
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      @(negedge clk_sys);
      d = reg_rd_data;
   endtask : rd
endmodule : host_model
`default_nettype wire

// [test_afe_timing_offset_gain_regs.sv]
// self-checking bench for the timing, offset and gain register bank
`timescale 1ns/100ps
`default_nettype none
module test_afe_timing_offset_gain_regs;
   logic clk_sys, rst, reg_wr_en, reg_rd_en, sync_timing_mode, reference_sample_pin, video_sample_pin;
   logic timing_pulse, reset_level_clamp;
   logic [5:0] reg_addr;
   logic [1:0] reference_sample_timing;
   logic [7:0] reg_wr_data, reg_rd_data, red_offset_code, green_offset_code, blue_offset_code, rv;
   logic [8:0] red_gain_code, green_gain_code, blue_gain_code;
   int fail_count = 0;
   int checks_done = 0;
   int n;
   afe_timing_offset_gain_regs u_afe_timing_offset_gain_regs (.clk_sys, .rst, .reg_wr_en, .reg_rd_en,
      .reg_addr, .reg_wr_data, .reg_rd_data, .sync_timing_mode, .reference_sample_timing,
      .reference_sample_pin, .video_sample_pin, .timing_pulse, .reset_level_clamp, .red_offset_code,
      .green_offset_code, .blue_offset_code, .red_gain_code, .green_gain_code, .blue_gain_code);
   host_model u_host_model (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data);
   // ****************************************
   // clock, verdict and shared checks
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
      u_host_model.rd(a, rv);
      chk("reg_rd_data", {1'b0, rv}, {1'b0, exp});
   endtask : rchk
   // moves the video pin, then notes when the timing output first rises and how long it stays up
   task automatic edge_test(input logic lvl, input int en, input int ew);
      int w;
      n = 0;
      w = 0;
      video_sample_pin = lvl;
      for (int i = 1; i <= 14; i++) begin
         @(negedge clk_sys);
         if (timing_pulse === 1'b1) begin
            w++;
            if (n == 0) n = i;
         end
      end
      chk("pulse_start", 9'(n), 9'(en));
      chk("pulse_width", 9'(w), 9'(ew));
   endtask : edge_test
   task automatic clamp_test(input logic r, input logic v, input logic exp);
      reference_sample_pin = r;
      video_sample_pin = v;
      repeat (3) @(negedge clk_sys);
      chk("clamp", {8'h00, reset_level_clamp}, {8'h00, exp});
   endtask : clamp_test
   // watchdog sized well beyond the few hundred cycles the sequence needs
   initial begin
      #(50 * 4000);
      fail_count++;
      wrap_up();
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      sync_timing_mode = 1'b0;
      reference_sample_timing = 2'h2;
      reference_sample_pin = 1'b0;
      video_sample_pin = 1'b0;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      rchk(afe_regs_pkg::SETUP_OFS, 8'h20);
      rchk(afe_regs_pkg::ID_OFS, 8'h00);
      chk("red_offset", {1'b0, red_offset_code}, 9'h000);
      rchk(afe_regs_pkg::GRN_MSB_OFS, 8'h0D);
      chk("red_gain", red_gain_code, 9'h01A);
      for (int i = 0; i < 3; i++) begin
         u_host_model.wr(afe_regs_pkg::ID_OFS, 8'h0F >> (i * 2));
         rchk(afe_regs_pkg::ID_OFS, 8'h0F >> (i * 2));
      end
      // per-channel offsets, then broadcast; broadcast and unmapped places read zero
      u_host_model.wr(afe_regs_pkg::RED_OFS_OFS, 8'h11);
      u_host_model.wr(afe_regs_pkg::GRN_OFS_OFS, 8'h22);
      u_host_model.wr(afe_regs_pkg::BLU_OFS_OFS, 8'hFF);
      chk("offsets", {red_offset_code, 1'b0}, 9'h022);
      chk("blue_offset", {1'b0, blue_offset_code}, 9'h0FF);
      rchk(afe_regs_pkg::GRN_OFS_OFS, 8'h22);
      u_host_model.wr(afe_regs_pkg::ALL_OFS_OFS, 8'h55);
      chk("red_offset", {1'b0, red_offset_code}, 9'h055);
      chk("green_offset", {1'b0, green_offset_code}, 9'h055);
      chk("blue_offset", {1'b0, blue_offset_code}, 9'h055);
      rchk(afe_regs_pkg::ALL_OFS_OFS, 8'h00);
      rchk(6'h3F, 8'h00);
      // gain codes pair the upper byte with the low bit
      u_host_model.wr(afe_regs_pkg::RED_LSB_OFS, 8'h01);
      u_host_model.wr(afe_regs_pkg::GRN_MSB_OFS, 8'h80);
      u_host_model.wr(afe_regs_pkg::BLU_MSB_OFS, 8'hC3);
      chk("red_gain", red_gain_code, 9'h01B);
      chk("green_gain", green_gain_code, 9'h100);
      chk("blue_gain", blue_gain_code, 9'h186);
      u_host_model.wr(afe_regs_pkg::ALL_LSB_OFS, 8'h01);
      chk("green_gain", green_gain_code, 9'h101);
      chk("blue_gain", blue_gain_code, 9'h187);
      u_host_model.wr(afe_regs_pkg::ALL_MSB_OFS, 8'hA5);
      chk("red_gain", red_gain_code, 9'h14B);
      chk("blue_gain", blue_gain_code, 9'h14B);
      // detector settings do nothing outside sync mode: the pin level passes through
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h35);
      edge_test(1'b1, 3, 12);
      edge_test(1'b0, 1, 2);
      sync_timing_mode = 1'b1;
      edge_test(1'b1, 6, 1);
      edge_test(1'b0, 0, 0);
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h34);
      edge_test(1'b1, 3, 12);
      // falling-edge detection at both ends of the delay field
      for (int d = 0; d < 8; d += 7) begin
         video_sample_pin = 1'b0;
         // let the low level reach the detector history first, else the new polarity sees a stray fall
         repeat (4) @(negedge clk_sys);
         u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h21 | 8'(d << 1));
         edge_test(1'b1, 0, 0);
         edge_test(1'b0, 4 + d, 1);
      end
      // clamp switch sources outside sync mode, then clamp enable cleared
      sync_timing_mode = 1'b0;
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h20);
      clamp_test(1'b1, 1'b0, 1'b1);
      clamp_test(1'b0, 1'b1, 1'b0);
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h60);
      clamp_test(1'b1, 1'b0, 1'b0);
      clamp_test(1'b1, 1'b1, 1'b1);
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h40);
      clamp_test(1'b1, 1'b1, 1'b0);
      // sync mode clamps once per four-cycle pixel while the video pin is low, whatever the reference pin and switch source say
      u_host_model.wr(afe_regs_pkg::SETUP_OFS, 8'h60);
      sync_timing_mode = 1'b1;
      // the pin's last fall restarts the pixel phase at zero, away from phase 2, so the switch is open
      clamp_test(1'b0, 1'b0, 1'b0);
      n = 0;
      repeat (8) begin
         @(negedge clk_sys);
         if (reset_level_clamp === 1'b1) n++;
      end
      chk("clamp_count", 9'(n), 9'h002);
      // phase is back at zero now, so a zero timing field closes the switch on the very next cycle
      reference_sample_timing = 2'h0;
      n = 0;
      for (int i = 1; i <= 4; i++) begin
         @(negedge clk_sys);
         if (reset_level_clamp === 1'b1 && n == 0) n = i;
      end
      chk("clamp_phase", 9'(n), 9'h001);
      wrap_up();
   end
endmodule : test_afe_timing_offset_gain_regs
`default_nettype wire
